//--- hw/cdrc_map.svh
// Register offsets, field positions, reset values and counts of the control register pair.
// Assumes inclusion by bare name from the design files of this block.
`ifndef CDRC_MAP_SVH
`define CDRC_MAP_SVH

// Sub-addresses of the two write-only registers on the serial management bus.
`define CDRC_OFS_LOCK_RESET 8'h09
`define CDRC_OFS_OUTPUT 8'h11

// Field positions in lock_and_reset_control.
`define CDRC_LR_PIN_CONFIG 7
`define CDRC_LR_CLR_STICKY 6
`define CDRC_LR_SYS_RESET 5
`define CDRC_LR_CLR_RATE 3

// Field positions in output_control.
`define CDRC_OC_BLANK_MODE 1
`define CDRC_OC_BOOST 0

// Every writable register comes out of reset at this value.
`define CDRC_REG_RESET 8'h00

// Slave address with bit 5 taken from the strap pin; the value is arbitrary.
`define CDRC_SLAVE_ADDR 7'h40
`define CDRC_ADDR_STRAP_BIT 5

// Data bits in one byte before the acknowledge slot.
`define CDRC_BYTE_BITS 4'h8

`endif

//--- hw/cdrc_pkg.sv
// Types shared by the control register block.
// Assumes nothing beyond a SystemVerilog compiler.
package cdrc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_SUB,
    ST_DATA,
    ST_IGNORE
  } cdrc_state_t;

endpackage : cdrc_pkg

//--- hw/cdrc_regs.sv
// Write-only control register pair with its serial management slave, sticky
// lock-loss and rate-done status, soft system reset and output blanking.
// Assumes a 40 MHz CLK well above the management bus rate, and that the
// lock detector and rate measurement run beside this block.
`timescale 1ns/100ps
`include "cdrc_map.svh"

module cdrc_regs
  import cdrc_pkg::*;
(
  // Clock, reset, enable.
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  // Serial management bus; SDA is open drain.
  input wire logic SCK,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic SLAVE_ADDR_STRAP,
  // Status sources.
  input wire logic LOCK_LOST_IN,
  input wire logic RATE_DONE_EVT,
  // Recovered stream from the retiming logic on CLK.
  input wire logic RECOVERED_CLOCK_IN,
  input wire logic RECOVERED_DATA_IN,
  input wire logic OUTPUT_BLANK_INPUT,
  // Pins and status toward the rest of the device.
  output logic LOCK_LOSS_PIN,
  output logic STICKY_LOCK_LOSS,
  output logic RATE_DONE,
  output logic SYSTEM_RESET,
  output logic RECOVERED_CLOCK_OUT,
  output logic RECOVERED_DATA_OUT,
  output logic OUTPUT_BOOST
);

  // A self-clearing action fires when a write takes a set bit back to zero.
  function automatic logic fell(input logic old_v, input logic new_v);
    return old_v & ~new_v;
  endfunction : fell

  logic [4:0] sync_lvl;
  logic scl_s, sda_s, strap_s, lock_s, blank_s;

  cdrc_sync3 #(.W(5)) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .pin_in({SCK, SDA_IN, SLAVE_ADDR_STRAP, LOCK_LOST_IN, OUTPUT_BLANK_INPUT}),
    .level_out(sync_lvl)
  );

  assign scl_s = sync_lvl[4];
  assign sda_s = sync_lvl[3];
  assign strap_s = sync_lvl[2];
  assign lock_s = sync_lvl[1];
  assign blank_s = sync_lvl[0];

  // Serial slave state.
  cdrc_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] sub_q, sub_d;
  logic ack_ph_q, ack_ph_d;
  logic oe_q, oe_d;
  logic scl_p_q, sda_p_q;
  logic wr_q, wr_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [7:0] wr_data_q, wr_data_d;
  logic strap_q, strap_d;
  logic start_c, stop_c, scl_rise, scl_fall;
  logic [6:0] my_addr;
  assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;

  always_comb begin
    my_addr = `CDRC_SLAVE_ADDR;
    my_addr[`CDRC_ADDR_STRAP_BIT] = strap_q;
  end
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    sub_d = sub_q;
    ack_ph_d = ack_ph_q;
    oe_d = oe_q;
    wr_d = 1'b0;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    strap_d = strap_q;
    // The strap is followed only between frames, so the address holds within one.
    if (st_q == ST_IDLE) begin
      strap_d = strap_s;
    end
    if (start_c) begin
      st_d = ST_ADDR;
      cnt_d = 4'h0;
      ack_ph_d = 1'b0;
      oe_d = 1'b0;
    end else if (stop_c) begin
      st_d = ST_IDLE;
      cnt_d = 4'h0;
      ack_ph_d = 1'b0;
      oe_d = 1'b0;
    end else if (st_q != ST_IDLE) begin
      if (scl_rise && cnt_q < `CDRC_BYTE_BITS) begin
        sh_d = {sh_q[6:0], sda_s};
        cnt_d = cnt_q + 4'h1;
      end
      if (scl_fall && cnt_q == `CDRC_BYTE_BITS) begin
        if (!ack_ph_q) begin
          ack_ph_d = 1'b1;
          case (st_q)
            ST_ADDR: begin
              // Only writes are taken; reads and other addresses go unanswered.
              if (sh_q[7:1] == my_addr && !sh_q[0]) begin
                oe_d = 1'b1;
                st_d = ST_SUB;
              end else begin
                st_d = ST_IGNORE;
              end
            end
            ST_SUB: begin
              sub_d = sh_q;
              oe_d = 1'b1;
              st_d = ST_DATA;
            end
            ST_DATA: begin
              wr_d = 1'b1;
              wr_addr_d = sub_q;
              wr_data_d = sh_q;
              sub_d = sub_q + 8'h01;
              oe_d = 1'b1;
            end
            default: begin
              oe_d = 1'b0;
            end
          endcase
        end else begin
          ack_ph_d = 1'b0;
          oe_d = 1'b0;
          cnt_d = 4'h0;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      sub_q <= 8'h00;
      ack_ph_q <= 1'b0;
      oe_q <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      wr_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
      strap_q <= 1'b0;
    end else if (CE) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      sub_q <= sub_d;
      ack_ph_q <= ack_ph_d;
      oe_q <= oe_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      wr_q <= wr_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      strap_q <= strap_d;
    end
  end

  assign SDA_OUT = 1'b0;
  assign SDA_OE = oe_q;
  // Register pair, status and soft reset.
  logic [7:0] lr_q, lr_d;
  logic [7:0] oc_q, oc_d;
  logic sticky_q, sticky_d;
  logic rate_q, rate_d;
  logic clr_sticky_q, clr_sticky_d;
  logic clr_rate_q, clr_rate_d;
  logic sys_rst_q, sys_rst_d;

  always_comb begin
    lr_d = lr_q;
    oc_d = oc_q;
    clr_sticky_d = 1'b0;
    clr_rate_d = 1'b0;
    sys_rst_d = 1'b0;
    if (sys_rst_q) begin
      // The soft reset returns both registers to their reset value.
      lr_d = `CDRC_REG_RESET;
      oc_d = `CDRC_REG_RESET;
    end else if (wr_q) begin
      // Unused bits are stored as written; the host keeps them zero.
      if (wr_addr_q == `CDRC_OFS_LOCK_RESET) begin
        lr_d = wr_data_q;
        clr_sticky_d = fell(lr_q[`CDRC_LR_CLR_STICKY], wr_data_q[`CDRC_LR_CLR_STICKY]);
        sys_rst_d = fell(lr_q[`CDRC_LR_SYS_RESET], wr_data_q[`CDRC_LR_SYS_RESET]);
        clr_rate_d = fell(lr_q[`CDRC_LR_CLR_RATE], wr_data_q[`CDRC_LR_CLR_RATE]);
      end else if (wr_addr_q == `CDRC_OFS_OUTPUT) begin
        oc_d = wr_data_q;
      end
    end
    // A new event wins over a clear arriving in the same cycle.
    sticky_d = lock_s | (sticky_q & ~clr_sticky_q & ~sys_rst_q);
    rate_d = RATE_DONE_EVT | (rate_q & ~clr_rate_q & ~sys_rst_q);
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      lr_q <= `CDRC_REG_RESET;
      oc_q <= `CDRC_REG_RESET;
      sticky_q <= 1'b0;
      rate_q <= 1'b0;
      clr_sticky_q <= 1'b0;
      clr_rate_q <= 1'b0;
      sys_rst_q <= 1'b0;
    end else if (CE) begin
      lr_q <= lr_d;
      oc_q <= oc_d;
      sticky_q <= sticky_d;
      rate_q <= rate_d;
      clr_sticky_q <= clr_sticky_d;
      clr_rate_q <= clr_rate_d;
      sys_rst_q <= sys_rst_d;
    end
  end

  // Output pins, all registered.
  logic lol_pin_q, lol_pin_d;
  logic rclk_q, rclk_d;
  logic rdata_q, rdata_d;
  logic boost_q, boost_d;

  always_comb begin
    // Live detector level or sticky copy, as configured.
    lol_pin_d = lr_q[`CDRC_LR_PIN_CONFIG] ? sticky_q : lock_s;
    rclk_d = RECOVERED_CLOCK_IN;
    rdata_d = RECOVERED_DATA_IN;
    if (!oc_q[`CDRC_OC_BLANK_MODE]) begin
      if (blank_s) begin
        rclk_d = 1'b0;
        rdata_d = 1'b0;
      end
    end else begin
      // Repeaters often need no clock, so low blank input drops it.
      if (blank_s) begin
        rdata_d = 1'b0;
      end else begin
        rclk_d = 1'b0;
      end
    end
    boost_d = oc_q[`CDRC_OC_BOOST];
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      lol_pin_q <= 1'b0;
      rclk_q <= 1'b0;
      rdata_q <= 1'b0;
      boost_q <= 1'b0;
    end else if (CE) begin
      lol_pin_q <= lol_pin_d;
      rclk_q <= rclk_d;
      rdata_q <= rdata_d;
      boost_q <= boost_d;
    end
  end

  assign LOCK_LOSS_PIN = lol_pin_q;
  assign STICKY_LOCK_LOSS = sticky_q;
  assign RATE_DONE = rate_q;
  assign SYSTEM_RESET = sys_rst_q;
  assign RECOVERED_CLOCK_OUT = rclk_q;
  assign RECOVERED_DATA_OUT = rdata_q;
  assign OUTPUT_BOOST = boost_q;

endmodule : cdrc_regs

//--- hw/cdrc_sync3.sv
// Three-stage synchroniser for pins that arrive from outside the clock domain.
// Assumes the caller reads only the filtered output.
`timescale 1ns/100ps
module cdrc_sync3 #(
  parameter int W = 1
) (
  // Clock, reset, enable.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Raw pins and filtered result.
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);

  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  // A bit changes only once the second and third stages agree.
  always_comb begin
    out_d = out_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else if (ce) begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign level_out = out_q;

endmodule : cdrc_sync3

//--- tb/cdrc_host.sv
// Management bus host that writes one register per frame.
// Assumes SDA has a pull-up, so the released line reads high.
`timescale 1ns/100ps
module cdrc_host (
  // Clock and device answer.
  input wire logic CLK,
  input wire logic SDA_OE,
  // Bus pins.
  output logic SCK,
  output logic SDA_IN
);
  logic sd = 1'b1;
  initial SCK = 1'b1;
  assign SDA_IN = sd & ~SDA_OE;
  task automatic wt(input int n);
    repeat (n) @(posedge CLK);
  endtask : wt
  // Each bus phase lasts 8 cycles, above the 5 the slave needs.
  task automatic wr(input logic [6:0] a, input logic [7:0] s, input logic [7:0] d,
    output logic ok);
    logic [23:0] f;
    f = {a, 1'b0, s, d};
    ok = 1'b1;
    sd <= 1'b0;
    wt(8);
    SCK <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sd <= f[i];
      wt(8);
      SCK <= 1'b1;
      wt(8);
      SCK <= 1'b0;
      if (i % 8 == 0) begin
        sd <= 1'b1;
        wt(8);
        SCK <= 1'b1;
        wt(4);
        ok &= ~SDA_IN;
        wt(4);
        SCK <= 1'b0;
      end
    end
    sd <= 1'b0;
    wt(8);
    SCK <= 1'b1;
    wt(8);
    sd <= 1'b1;
    wt(8);
  endtask : wr
endmodule : cdrc_host

//--- tb/cdrc_regs_bench.sv
// Self-checking bench for the control register block.
// Assumes the host model drives the management bus and the bench every other input.
`timescale 1ns/100ps
`include "cdrc_map.svh"
module cdrc_regs_bench;
  logic CLK, RST_N, SCK, SDA_IN, SDA_OUT, SDA_OE, LK, EV, RCI, RDI, BLK;
  logic PIN, STK, RD, SR, RCO, RDO, BST, sr_seen, CEN, STRAP;
  int mismatches = 0;
  int num_checks = 0;
  localparam logic [7:0] LR = `CDRC_OFS_LOCK_RESET;
  localparam logic [7:0] OC = `CDRC_OFS_OUTPUT;
  localparam logic [6:0] ADR1 = `CDRC_SLAVE_ADDR | (7'h01 << `CDRC_ADDR_STRAP_BIT);
  cdrc_host i_host (.CLK(CLK), .SDA_OE(SDA_OE), .SCK(SCK), .SDA_IN(SDA_IN));
  cdrc_regs i_dut (.CLK(CLK), .RST_N(RST_N), .CE(CEN), .SCK(SCK), .SDA_IN(SDA_IN),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SLAVE_ADDR_STRAP(STRAP), .LOCK_LOST_IN(LK),
    .RATE_DONE_EVT(EV), .RECOVERED_CLOCK_IN(RCI), .RECOVERED_DATA_IN(RDI),
    .OUTPUT_BLANK_INPUT(BLK), .LOCK_LOSS_PIN(PIN), .STICKY_LOCK_LOSS(STK),
    .RATE_DONE(RD), .SYSTEM_RESET(SR), .RECOVERED_CLOCK_OUT(RCO),
    .RECOVERED_DATA_OUT(RDO), .OUTPUT_BOOST(BST));
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  always @(posedge CLK) if (SR === 1'b1) sr_seen <= 1'b1;
  task automatic chk(input logic g, input logic e, input string m);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  task automatic w(input logic [7:0] s, input logic [7:0] d);
    logic ok;
    i_host.wr(`CDRC_SLAVE_ADDR, s, d, ok);
    chk(ok, 1'b1, "no ack");
  endtask : w
  task automatic pulse_in();
    LK <= 1'b1;
    EV <= 1'b1;
    i_host.wt(1);
    EV <= 1'b0;
    i_host.wt(10);
    chk(PIN, 1'b1, "live pin");
    LK <= 1'b0;
    i_host.wt(10);
  endtask : pulse_in
  task automatic t_boost();
    chk(BST, 1'b0, "boost reset");
    chk(STK | RD | PIN, 1'b0, "status reset");
    w(OC, 8'h01);
    chk(BST, 1'b1, "boost on");
    w(OC, 8'h00);
    chk(BST, 1'b0, "boost off");
    $display("test boost done");
  endtask : t_boost
  task automatic t_blank();
    RCI <= 1'b1;
    RDI <= 1'b1;
    BLK <= 1'b1;
    i_host.wt(10);
    chk(RCO | RDO, 1'b0, "mode0 blank");
    w(OC, 8'h02);
    chk(RCO, 1'b1, "mode1 clock");
    chk(RDO, 1'b0, "mode1 data");
    BLK <= 1'b0;
    i_host.wt(10);
    chk(RCO, 1'b0, "mode1 low clock");
    chk(RDO, 1'b1, "mode1 low data");
    w(OC, 8'h00);
    chk(RCO & RDO, 1'b1, "mode0 pass");
    $display("test blank done");
  endtask : t_blank
  task automatic t_lock();
    pulse_in();
    chk(STK, 1'b1, "sticky kept");
    chk(PIN, 1'b0, "normal pin");
    w(LR, 8'h80);
    chk(PIN, 1'b1, "static pin");
    w(LR, 8'hc0);
    chk(STK, 1'b1, "one alone");
    w(LR, 8'h80);
    chk(STK | PIN, 1'b0, "sticky cleared");
    chk(RD, 1'b1, "rate kept");
    w(LR, 8'h08);
    w(LR, 8'h00);
    chk(RD, 1'b0, "rate cleared");
    $display("test lock done");
  endtask : t_lock
  task automatic t_sys();
    logic ok;
    i_host.wr(`CDRC_SLAVE_ADDR ^ 7'h01, OC, 8'h01, ok);
    chk(ok | BST, 1'b0, "wrong address");
    w(OC, 8'h01);
    pulse_in();
    sr_seen <= 1'b0;
    w(LR, 8'h20);
    chk(sr_seen, 1'b0, "early reset");
    w(LR, 8'h00);
    chk(sr_seen, 1'b1, "soft reset");
    chk(BST | STK | RD, 1'b0, "state after reset");
    $display("test sys done");
  endtask : t_sys
  task automatic t_strap();
    logic ok;
    STRAP <= 1'b1;
    i_host.wt(10);
    i_host.wr(ADR1, OC, 8'h01, ok);
    chk(ok & BST, 1'b1, "strap address");
    i_host.wr(`CDRC_SLAVE_ADDR, OC, 8'h00, ok);
    chk(ok | ~BST, 1'b0, "old address");
    STRAP <= 1'b0;
    i_host.wt(10);
    w(OC, 8'h00);
    chk(BST, 1'b0, "boost cleared");
    $display("test strap done");
  endtask : t_strap
  task automatic t_ce();
    CEN <= 1'b0;
    EV <= 1'b1;
    RDI <= 1'b0;
    i_host.wt(1);
    EV <= 1'b0;
    i_host.wt(4);
    chk(RD, 1'b0, "frozen rate");
    chk(RDO, 1'b1, "frozen data");
    CEN <= 1'b1;
    i_host.wt(2);
    chk(RDO, 1'b0, "running data");
    $display("test ce done");
  endtask : t_ce
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    repeat (30000) @(posedge CLK);
    mismatches++;
    end_sim();
  end
  initial begin
    {RST_N, LK, EV, RCI, RDI, BLK, sr_seen, STRAP} = 8'h00;
    CEN = 1'b1;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    i_host.wt(10);
    t_boost();
    t_blank();
    t_lock();
    t_sys();
    t_strap();
    t_ce();
    end_sim();
  end
endmodule : cdrc_regs_bench

//--- tb/cdrc_regs_sva.sv
// Port checker for the control register block.
// Assumes it is bound to cdrc_regs and CE stays high around a soft reset.
`timescale 1ns/100ps
module cdrc_regs_sva (
  // Clock and control.
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  // Inputs.
  input wire logic LOCK_LOST_IN,
  input wire logic RATE_DONE_EVT,
  input wire logic RECOVERED_CLOCK_IN,
  input wire logic RECOVERED_DATA_IN,
  input wire logic OUTPUT_BLANK_INPUT,
  // Outputs.
  input wire logic LOCK_LOSS_PIN,
  input wire logic STICKY_LOCK_LOSS,
  input wire logic RATE_DONE,
  input wire logic SYSTEM_RESET,
  input wire logic RECOVERED_CLOCK_OUT,
  input wire logic RECOVERED_DATA_OUT,
  input wire logic OUTPUT_BOOST
);
  logic [7:0] lk_q;
  logic [3:0] blk_q;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // A lock loss must pass the synchroniser before the sticky bit may rise.
  always_ff @(posedge CLK) if (CE) lk_q <= {lk_q[6:0], LOCK_LOST_IN};
  // Counts enabled cycles of a steady blank level, well past the synchroniser delay.
  always_ff @(posedge CLK) begin
    if (!RST_N || !OUTPUT_BLANK_INPUT) begin
      blk_q <= 4'h0;
    end else if (CE && blk_q != 4'hf) begin
      blk_q <= blk_q + 4'h1;
    end
  end
  blank_data_a: assert property (blk_q >= 4'h6 |-> !RECOVERED_DATA_OUT)
    else $error("data out while blanked");
  rate_set_a: assert property (CE && RATE_DONE_EVT |=> RATE_DONE)
    else $error("rate done not set");
  rate_cause_a: assert property ($rose(RATE_DONE) |-> $past(RATE_DONE_EVT))
    else $error("rate done rose alone");
  sticky_cause_a: assert property ($rose(STICKY_LOCK_LOSS) |-> |lk_q[7:1])
    else $error("sticky rose alone");
  pin_source_a: assert property (LOCK_LOSS_PIN |-> STICKY_LOCK_LOSS ||
    $past(STICKY_LOCK_LOSS)) else $error("lock pin without loss");
  data_path_a: assert property ($past(CE) && RECOVERED_DATA_OUT |->
    $past(RECOVERED_DATA_IN)) else $error("data out not from input");
  clock_path_a: assert property ($past(CE) && RECOVERED_CLOCK_OUT |->
    $past(RECOVERED_CLOCK_IN)) else $error("clock out not from input");
  reset_pulse_a: assert property (SYSTEM_RESET && CE |=> !SYSTEM_RESET)
    else $error("soft reset too long");
  reset_clear_a: assert property (SYSTEM_RESET && !RATE_DONE_EVT |-> ##[1:2]
    (!RATE_DONE && !OUTPUT_BOOST && !STICKY_LOCK_LOSS)) else $error("soft reset left state");
endmodule : cdrc_regs_sva
bind cdrc_regs cdrc_regs_sva i_sva (.CLK, .RST_N, .CE, .LOCK_LOST_IN, .RATE_DONE_EVT,
  .RECOVERED_CLOCK_IN, .RECOVERED_DATA_IN, .OUTPUT_BLANK_INPUT, .LOCK_LOSS_PIN,
  .STICKY_LOCK_LOSS, .RATE_DONE,
  .SYSTEM_RESET, .RECOVERED_CLOCK_OUT, .RECOVERED_DATA_OUT, .OUTPUT_BOOST);
